// ==== hdl/adc_seq_pkg.sv ====
package adc_seq_pkg;

    // Command words
    localparam logic [15:0] CMD_HOLD       = 16'h0000;
    localparam logic [15:0] CMD_LIGHT      = 16'h8200;
    localparam logic [15:0] CMD_SLEEP      = 16'h8300;
    localparam logic [15:0] CMD_REGRST     = 16'h8500;
    localparam logic [15:0] CMD_AUTO       = 16'ha000;
    localparam logic [15:0] CMD_FIXED_BASE = 16'hc000;
    localparam logic [15:0] CMD_FIXED_MASK = 16'he3ff;
    localparam logic [15:0] CMD_AUX        = 16'he000;
    localparam int          CH_POS         = 10;
    localparam int          CMD_FLAG_POS   = 15;
    localparam int          WR_FLAG_POS    = 8;
    localparam int          ADDR_POS       = 9;

    // Program register offsets
    localparam logic [6:0] REG_SCAN_SEL = 7'h01;
    localparam logic [6:0] REG_SCAN_PWR = 7'h02;
    localparam logic [6:0] REG_REF_CFG  = 7'h03;
    localparam logic [6:0] REG_RANGE0   = 7'h05;
    localparam int         NREG         = 16;
    localparam int         REF_SEL_POS  = 0;

    // Values after reset
    localparam logic [7:0] SCAN_SEL_RST = 8'hff;
    localparam logic [7:0] SCAN_PWR_RST = 8'h00;
    localparam logic [7:0] REF_CFG_RST  = 8'h00;
    localparam logic [7:0] RANGE_RST    = 8'h00;
    localparam logic [7:0] OTHER_RST    = 8'h00;

    // Frame and data layout
    localparam logic [5:0]  CMD_BITS     = 6'h10;
    localparam int          CONV_BITS    = 14;
    localparam logic [15:0] INVALID_DATA = 16'hffff;
    localparam logic [3:0]  AUX_CH       = 4'h8;
    localparam int          N_CH         = 8;

    // Reference settling after waking from sleep
    localparam int SETTLE_MS     = 15;
    localparam int CLK_HZ        = 10_000_000;
    localparam int SETTLE_CYCLES = SETTLE_MS * (CLK_HZ / 1000);

    typedef enum logic [2:0] {
        M_IDLE, M_LIGHT, M_SLEEP, M_REGRST, M_AUTO, M_FIXED, M_INVALID
    } mode_e;

endpackage

// ==== hdl/frame_if.sv ====
`timescale 1ns/1ps
// Frame events from the serial front end to the command logic
interface frame_if;
    logic        start;
    logic        stop;
    logic        sfall;
    logic        srise;
    logic        got16;
    logic [5:0]  cnt;
    logic [15:0] word;

    modport src  (output start, stop, sfall, srise, got16, cnt, word);
    modport sink (input  start, stop, sfall, srise, got16, cnt, word);
endinterface

// ==== hdl/serial_frame.sv ====
`timescale 1ns/1ps
module serial_frame (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Link pins, asynchronous to clk
    input  wire logic cs_n,
    input  wire logic sclk,
    input  wire logic sdi,
    // Frame events
    frame_if.src      fb
);
    import adc_seq_pkg::*;

    logic [2:0]  cs_p_r,  cs_p_nxt;
    logic [2:0]  ck_p_r,  ck_p_nxt;
    logic [1:0]  di_p_r,  di_p_nxt;
    logic [5:0]  cnt_r,   cnt_nxt;
    logic [15:0] word_r,  word_nxt;
    logic        start_r, start_nxt;
    logic        stop_r,  stop_nxt;
    logic        fall_r,  fall_nxt;
    logic        rise_r,  rise_nxt;
    logic        got_r,   got_nxt;
    logic        in_frame;

    // Two stages of sync, the third stage only feeds edge detection
    always_comb begin
        cs_p_nxt  = {cs_p_r[1:0], cs_n};
        ck_p_nxt  = {ck_p_r[1:0], sclk};
        di_p_nxt  = {di_p_r[0], sdi};
        in_frame  = !cs_p_r[1];
        start_nxt = cs_p_r[2] && !cs_p_r[1];
        stop_nxt  = !cs_p_r[2] && cs_p_r[1];
        fall_nxt  = in_frame && ck_p_r[2] && !ck_p_r[1];
        rise_nxt  = in_frame && !ck_p_r[2] && ck_p_r[1];
        cnt_nxt   = cnt_r;
        word_nxt  = word_r;
        got_nxt   = 1'b0;
        if (start_nxt) begin
            cnt_nxt = 6'h00;
        end else if (fall_nxt && cnt_r != 6'h3f) begin
            // Command bits are taken on the falling clock edge, MSB first
            cnt_nxt = cnt_r + 6'h01;
            if (cnt_r < CMD_BITS) begin
                word_nxt = {word_r[14:0], di_p_r[1]};
            end
            got_nxt = (cnt_nxt == CMD_BITS);
        end
    end

    // Front end registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_p_r  <= 3'h7;
            ck_p_r  <= 3'h0;
            di_p_r  <= 2'h0;
            cnt_r   <= 6'h00;
            word_r  <= 16'h0000;
            start_r <= 1'b0;
            stop_r  <= 1'b0;
            fall_r  <= 1'b0;
            rise_r  <= 1'b0;
            got_r   <= 1'b0;
        end else begin
            cs_p_r  <= cs_p_nxt;
            ck_p_r  <= ck_p_nxt;
            di_p_r  <= di_p_nxt;
            cnt_r   <= cnt_nxt;
            word_r  <= word_nxt;
            start_r <= start_nxt;
            stop_r  <= stop_nxt;
            fall_r  <= fall_nxt;
            rise_r  <= rise_nxt;
            got_r   <= got_nxt;
        end
    end

    // Events are one-cycle pulses, count and word stand between them
    assign fb.start = start_r;
    assign fb.stop  = stop_r;
    assign fb.sfall = fall_r;
    assign fb.srise = rise_r;
    assign fb.got16 = got_r;
    assign fb.cnt   = cnt_r;
    assign fb.word  = word_r;

endmodule // serial_frame

// ==== hdl/adc_mode_command_sequencer.sv ====
`timescale 1ns/1ps
module adc_mode_command_sequencer #(
    parameter int SETTLE_CYCLES = adc_seq_pkg::SETTLE_CYCLES,
    parameter int NUM_CH        = adc_seq_pkg::N_CH
) (
    // Clock and reset
    input  wire logic                             CLK,
    input  wire logic                             RST_N,
    // Serial link pins
    input  wire logic                             CS_N,
    input  wire logic                             SCLK,
    input  wire logic                             SDI,
    output logic                                  SDO,
    output logic                                  SDO_OE,
    // Hardware sleep pin, low forces power-down and register reset
    input  wire logic                             HW_SLEEP_N,
    // Converter core, same clock domain
    input  wire logic [adc_seq_pkg::CONV_BITS-1:0] CONV_DATA,
    output logic                                  SAMPLE,
    output logic [3:0]                            CHANNEL,
    output logic [7:0]                            RANGE,
    output logic [7:0]                            CH_POWER,
    output logic                                  ANALOG_ON,
    output logic                                  REF_ON,
    output logic                                  SETTLED
);
    import adc_seq_pkg::*;

    localparam int SW = $clog2(SETTLE_CYCLES + 1);
    localparam logic [SW-1:0] SETTLE_LOAD = SW'(SETTLE_CYCLES);

    frame_if fb ();

    serial_frame u_frame (
        .clk   (CLK),
        .rst_n (RST_N),
        .cs_n  (CS_N),
        .sclk  (SCLK),
        .sdi   (SDI),
        .fb    (fb.src)
    );

    mode_e          mode_r,    mode_nxt;
    logic           restart_r, restart_nxt;
    logic [3:0]     chan_r,    chan_nxt;
    logic [15:0]    pend_r,    pend_nxt;
    logic           got_r,     got_nxt;
    logic           conv_r,    conv_nxt;
    logic [15:0]    shift_r,   shift_nxt;
    logic           sdo_r,     sdo_nxt;
    logic           oe_r,      oe_nxt;
    logic           sample_r,  sample_nxt;
    logic [7:0]     range_r,   range_nxt;
    logic [7:0]     chpwr_r,   chpwr_nxt;
    logic           aon_r,     aon_nxt;
    logic           settled_r, settled_nxt;
    logic [SW-1:0]  settle_r,  settle_nxt;
    logic           hw_s1_r,   hw_s2_r;
    logic [7:0]     prog_r [NREG];
    logic [7:0]     prog_nxt [NREG];
    logic           regrst;
    logic           asleep;
    logic           hw_low;
    logic [6:0]     addr;
    logic [7:0]     sel;

    // Default contents of each program register
    function automatic logic [7:0] reg_default(input int idx);
        if (idx == int'(REG_SCAN_SEL)) begin
            return SCAN_SEL_RST;
        end else if (idx == int'(REG_SCAN_PWR)) begin
            return SCAN_PWR_RST;
        end else if (idx == int'(REG_REF_CFG)) begin
            return REF_CFG_RST;
        end else if (idx >= int'(REG_RANGE0)
                     && idx < int'(REG_RANGE0) + N_CH) begin
            return RANGE_RST;
        end else begin
            return OTHER_RST;
        end
    endfunction

    // Next selected channel above cur, wrapping to the lowest selected
    function automatic logic [3:0] next_sel(input logic [7:0] s,
                                           input logic [3:0] cur,
                                           input logic       from_low);
        logic [3:0] lo;
        logic [3:0] hi;
        logic       found;
        lo    = 4'h0;
        hi    = 4'h0;
        found = 1'b0;
        for (int i = N_CH - 1; i >= 0; i--) begin
            if (s[i]) begin
                lo = 4'(i);
                if (!from_low && 4'(i) > cur) begin
                    hi    = 4'(i);
                    found = 1'b1;
                end
            end
        end
        return found ? hi : lo;
    endfunction

    // Pin sync; only the second stage is read
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            hw_s1_r <= 1'b1;
            hw_s2_r <= 1'b1;
        end else begin
            hw_s1_r <= HW_SLEEP_N;
            hw_s2_r <= hw_s1_r;
        end
    end

    assign hw_low = !hw_s2_r;
    assign addr   = fb.word[ADDR_POS +: 7];
    assign sel    = prog_r[REG_SCAN_SEL[3:0]];

    // Command decode, frame sequencing and program register updates
    always_comb begin
        mode_nxt    = mode_r;
        restart_nxt = restart_r;
        chan_nxt    = chan_r;
        pend_nxt    = pend_r;
        got_nxt     = got_r;
        conv_nxt    = conv_r;
        shift_nxt   = shift_r;
        sdo_nxt     = sdo_r;
        oe_nxt      = oe_r;
        sample_nxt  = 1'b0;
        range_nxt   = range_r;
        prog_nxt    = prog_r;
        regrst      = 1'b0;

        if (fb.start) begin
            oe_nxt   = 1'b1;
            sdo_nxt  = 1'b0;
            got_nxt  = 1'b0;
            conv_nxt = 1'b0;
            if (mode_r == M_AUTO) begin
                chan_nxt    = next_sel(sel, chan_r, restart_r);
                restart_nxt = 1'b0;
            end
            if (mode_r == M_AUTO || mode_r == M_FIXED) begin
                sample_nxt = 1'b1;
                conv_nxt   = 1'b1;
                if (chan_nxt < AUX_CH) begin
                    range_nxt = prog_r[REG_RANGE0[3:0] + chan_nxt];
                end else begin
                    range_nxt = RANGE_RST;
                end
            end
        end

        // Sixteenth falling clock: command word complete
        if (fb.got16) begin
            got_nxt  = 1'b1;
            pend_nxt = fb.word;
            if (!fb.word[CMD_FLAG_POS] && fb.word != CMD_HOLD) begin
                if (fb.word[WR_FLAG_POS]) begin
                    shift_nxt = {fb.word[7:0], 8'h00};
                    if (addr < 7'(NREG)) begin
                        prog_nxt[addr[3:0]] = fb.word[7:0];
                    end
                end else if (addr < 7'(NREG)) begin
                    shift_nxt = {prog_r[addr[3:0]], 8'h00};
                end else begin
                    shift_nxt = 16'h0000;
                end
            end else if (conv_r) begin
                shift_nxt = {CONV_DATA, 2'b00};
            end else begin
                shift_nxt = INVALID_DATA;
            end
        end

        // Data leaves MSB first on rising clocks after the command
        if (fb.srise && fb.cnt >= CMD_BITS) begin
            sdo_nxt   = shift_r[15];
            shift_nxt = {shift_r[14:0], 1'b0};
        end

        if (fb.stop) begin
            oe_nxt  = 1'b0;
            sdo_nxt = 1'b0;
            if (!got_r) begin
                mode_nxt = M_INVALID;
            end else if (pend_r == CMD_HOLD) begin
                mode_nxt = mode_r;
            end else if (pend_r[CMD_FLAG_POS]) begin
                if (pend_r == CMD_LIGHT) begin
                    mode_nxt = M_LIGHT;
                end else if (pend_r == CMD_SLEEP) begin
                    mode_nxt = M_SLEEP;
                end else if (pend_r == CMD_REGRST) begin
                    mode_nxt = M_REGRST;
                    regrst   = 1'b1;
                end else if (pend_r == CMD_AUTO) begin
                    mode_nxt    = M_AUTO;
                    restart_nxt = 1'b1;
                end else if (pend_r == CMD_AUX) begin
                    mode_nxt = M_FIXED;
                    chan_nxt = AUX_CH;
                end else if ((pend_r & CMD_FIXED_MASK) == CMD_FIXED_BASE
                             && 32'(pend_r[CH_POS +: 3]) < NUM_CH) begin
                    mode_nxt = M_FIXED;
                    chan_nxt = {1'b0, pend_r[CH_POS +: 3]};
                end else begin
                    mode_nxt = M_INVALID;
                end
            end
        end

        if (hw_low) begin
            mode_nxt    = M_REGRST;
            restart_nxt = 1'b0;
            regrst      = 1'b1;
        end
        if (regrst) begin
            for (int i = 0; i < NREG; i++) begin
                prog_nxt[i] = reg_default(i);
            end
        end
    end

    // Control and program register state
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode_r    <= M_IDLE;
            restart_r <= 1'b0;
            chan_r    <= 4'h0;
            pend_r    <= 16'h0000;
            got_r     <= 1'b0;
            conv_r    <= 1'b0;
            shift_r   <= 16'h0000;
            sdo_r     <= 1'b0;
            oe_r      <= 1'b0;
            sample_r  <= 1'b0;
            range_r   <= RANGE_RST;
            for (int i = 0; i < NREG; i++) begin
                prog_r[i] <= reg_default(i);
            end
        end else begin
            mode_r    <= mode_nxt;
            restart_r <= restart_nxt;
            chan_r    <= chan_nxt;
            pend_r    <= pend_nxt;
            got_r     <= got_nxt;
            conv_r    <= conv_nxt;
            shift_r   <= shift_nxt;
            sdo_r     <= sdo_nxt;
            oe_r      <= oe_nxt;
            sample_r  <= sample_nxt;
            range_r   <= range_nxt;
            prog_r    <= prog_nxt;
        end
    end

    // Power and settling; standby keeps the reference running
    always_comb begin
        asleep    = (mode_nxt == M_SLEEP) || hw_low;
        aon_nxt   = !asleep;
        chpwr_nxt = 8'h00;
        if (!asleep && mode_nxt != M_LIGHT) begin
            if (mode_nxt == M_AUTO) begin
                chpwr_nxt = ~prog_nxt[REG_SCAN_PWR[3:0]];
            end else begin
                chpwr_nxt = 8'hff;
            end
        end
        if (asleep) begin
            settle_nxt = SETTLE_LOAD;
        end else if (prog_nxt[REG_REF_CFG[3:0]][REF_SEL_POS]) begin
            settle_nxt = '0;
        end else if (settle_r != '0) begin
            settle_nxt = settle_r - SW'(1);
        end else begin
            settle_nxt = settle_r;
        end
        settled_nxt = !asleep && settle_nxt == '0;
    end

    // Power outputs registered
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            chpwr_r   <= 8'h00;
            aon_r     <= 1'b0;
            settle_r  <= SETTLE_LOAD;
            settled_r <= 1'b0;
        end else begin
            chpwr_r   <= chpwr_nxt;
            aon_r     <= aon_nxt;
            settle_r  <= settle_nxt;
            settled_r <= settled_nxt;
        end
    end

    assign SDO       = sdo_r;
    assign SDO_OE    = oe_r;
    assign SAMPLE    = sample_r;
    assign CHANNEL   = chan_r;
    assign RANGE     = range_r;
    assign CH_POWER  = chpwr_r;
    assign ANALOG_ON = aon_r;
    assign REF_ON    = aon_r;
    assign SETTLED   = settled_r;

endmodule // adc_mode_command_sequencer

// ==== dv/adc_seq_checker_props.sv ====
`timescale 1ns/1ps
module adc_seq_checker (
    // Clock and reset
    input wire logic       CLK,
    input wire logic       RST_N,
    // Watched pins and core outputs
    input wire logic       CS_N,
    input wire logic       SDO_OE,
    input wire logic       HW_SLEEP_N,
    input wire logic       SAMPLE,
    input wire logic [3:0] CHANNEL,
    input wire logic [7:0] CH_POWER,
    input wire logic       ANALOG_ON,
    input wire logic       REF_ON,
    input wire logic       SETTLED
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    chk_sample_one_cycle: assert property (
        SAMPLE |=> !SAMPLE) else $error("sample pulse too long");
    chk_sample_at_fall: assert property (
        SAMPLE |-> !CS_N && ($past(CS_N, 3) || $past(CS_N, 4) ||
        $past(CS_N, 5) || $past(CS_N, 6)))
        else $error("sample away from frame start");
    chk_sleep_all_off: assert property (
        !ANALOG_ON |-> !REF_ON && CH_POWER == 8'h00)
        else $error("circuit powered while asleep");
    chk_no_settle_asleep: assert property (
        !ANALOG_ON |-> !SETTLED) else $error("settled while asleep");
    chk_settle_wait: assert property (
        $rose(ANALOG_ON) |-> !SETTLED [*8]) else $error("settled early");
    chk_pin_forces: assert property (
        !HW_SLEEP_N [*5] |-> !ANALOG_ON) else $error("pin sleep ignored");
    chk_no_conv_asleep: assert property (
        SAMPLE |-> ANALOG_ON) else $error("sample while asleep");
    chk_channel_legal: assert property (
        CHANNEL <= 4'h8) else $error("channel out of range");
    // Output driver follows the frame, a few cycles of sync delay
    chk_oe_in_frame: assert property (
        !CS_N [*8] |-> SDO_OE) else $error("data line not driven in frame");
    chk_oe_released: assert property (
        CS_N [*8] |-> !SDO_OE) else $error("data line driven outside frame");
endmodule // adc_seq_checker

bind adc_mode_command_sequencer adc_seq_checker chk_u (
    .CLK(CLK), .RST_N(RST_N), .CS_N(CS_N), .SDO_OE(SDO_OE),
    .HW_SLEEP_N(HW_SLEEP_N),
    .SAMPLE(SAMPLE), .CHANNEL(CHANNEL), .CH_POWER(CH_POWER),
    .ANALOG_ON(ANALOG_ON), .REF_ON(REF_ON), .SETTLED(SETTLED));

// ==== dv/host_link_model.sv ====
`timescale 1ns/1ps
module host_link_model (
    // Clock
    input  wire logic CLK,
    // Link pins
    output logic      CS_N,
    output logic      SCLK,
    output logic      SDI,
    input  wire logic SDO
);
    // Idle: deselected, link clock parked low
    initial begin
        CS_N = 1'b1;
        SCLK = 1'b0;
        SDI  = 1'b0;
    end

    // One frame of n clocks; SDO taken one CLK cycle after each fall
    task automatic frame(input logic [15:0] w, input int n,
                         output logic [31:0] rx);
        rx = '0;
        @(posedge CLK) CS_N <= 1'b0;
        repeat (8) @(posedge CLK);
        // word MSB first, zeros after 16 bits; a short frame sends only its top n bits
        for (int i = 0; i < n; i++) begin
            SDI <= (i < 16) ? w[15-i] : 1'b0;
            repeat (2) @(posedge CLK);
            SCLK <= 1'b1;
            repeat (4) @(posedge CLK);
            SCLK <= 1'b0;
            @(posedge CLK);
            rx = {rx[30:0], SDO};
            @(posedge CLK);
        end
        repeat (4) @(posedge CLK);
        CS_N <= 1'b1;
        // Released data line must not keep the last bit
        SDI  <= ~SDI;
        repeat (8) @(posedge CLK);
    endtask
endmodule // host_link_model

// ==== dv/adc_mode_command_sequencer_test.sv ====
`timescale 1ns/1ps
module adc_mode_command_sequencer_test;
    import adc_seq_pkg::*;
    localparam int          SETTLE = 20;
    localparam logic [13:0] CONV   = 14'h1abc;
    // Bench signals
    logic        clk, rst_n, hw_sleep_n, cs_n, sclk, sdi, sdo;
    logic        sample, analog_on, ref_on, settled;
    logic [3:0]  channel;
    logic [7:0]  range_q, ch_power;
    logic [13:0] conv_data;
    logic [31:0] rx;
    int          errors, n_tests, n_samp;

    host_link_model host_u (.CLK(clk), .CS_N(cs_n), .SCLK(sclk),
        .SDI(sdi), .SDO(sdo));
    adc_mode_command_sequencer #(.SETTLE_CYCLES(SETTLE), .NUM_CH(N_CH))
        dut_u (.CLK(clk), .RST_N(rst_n), .CS_N(cs_n), .SCLK(sclk),
        .SDI(sdi), .SDO(sdo), .SDO_OE(), .HW_SLEEP_N(hw_sleep_n),
        .CONV_DATA(conv_data), .SAMPLE(sample), .CHANNEL(channel),
        .RANGE(range_q), .CH_POWER(ch_power), .ANALOG_ON(analog_on),
        .REF_ON(ref_on), .SETTLED(settled));

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Count conversion starts
    always @(posedge clk) if (sample === 1'b1) n_samp <= n_samp + 1;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic fr(input logic [15:0] w, input int n);
        host_u.frame(w, n, rx);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        fr({a, 1'b1, d}, 16);
    endtask
    task automatic rd(input logic [6:0] a);
        fr({a, 1'b0, 8'h00}, 24);
    endtask

    task automatic t_defaults();
        rd(REG_SCAN_SEL);
        chk(rx[7:0], 16'h00ff);
        rd(REG_SCAN_PWR);
        chk(rx[7:0], 16'h0000);
        rd(7'h10);
        chk(rx[7:0], 16'h0000);
    endtask

    task automatic t_manual();
        int s;
        for (int c = 0; c < 9; c++) begin
            fr(c < 8 ? CMD_FIXED_BASE | 16'(c << CH_POS) : CMD_AUX, 16);
            fr(CMD_HOLD, 16);
            chk(channel, c < 8 ? 16'(c) : 16'(AUX_CH));
        end
        fr(16'hc400, 16);
        s = n_samp;
        fr(CMD_HOLD, 32);
        chk(rx[15:0], {CONV, 2'b00});
        fr(CMD_HOLD, 16);
        chk(channel, 16'h1);
        chk(16'(n_samp - s), 16'h2);
    endtask

    task automatic t_auto();
        wr(REG_SCAN_SEL, 8'h25);
        wr(REG_SCAN_PWR, 8'h02);
        wr(REG_RANGE0 + 7'h2, 8'h03);
        fr(CMD_AUTO, 16);
        fr(CMD_HOLD, 16);
        chk(channel, 16'h0);
        chk(ch_power, 16'hfd);
        fr(CMD_HOLD, 16);
        chk(channel, 16'h2);
        chk(range_q, 16'h3);
        fr(CMD_HOLD, 16);
        chk(channel, 16'h5);
        fr(CMD_AUTO, 16);
        chk(channel, 16'h0);
        fr(CMD_HOLD, 16);
        chk(channel, 16'h0);
    endtask

    task automatic t_sleep();
        int s;
        fr(CMD_SLEEP, 16);
        chk(analog_on, 16'h0);
        chk({ref_on, settled, ch_power}, 16'h0);
        s = n_samp;
        fr(CMD_HOLD, 32);
        chk(rx[15:0], INVALID_DATA);
        wr(REG_RANGE0 + 7'h1, 8'h5a);
        rd(REG_RANGE0 + 7'h1);
        chk(rx[7:0], 16'h005a);
        chk({analog_on, 15'(n_samp - s)}, 16'h0);
        fr(16'hc400, 16);
        chk({analog_on, settled}, 16'h2);
        for (int i = 0; i < 100 && settled !== 1'b1; i++) @(posedge clk);
        chk(settled, 16'h1);
        rd(REG_RANGE0 + 7'h1);
        chk(rx[7:0], 16'h005a);
    endtask

    task automatic t_regrst();
        int s;
        wr(REG_SCAN_SEL, 8'h0f);
        fr(CMD_REGRST, 16);
        rd(REG_RANGE0 + 7'h1);
        chk(rx[7:0], 16'h0000);
        rd(REG_SCAN_SEL);
        chk(rx[7:0], 16'h00ff);
        s = n_samp;
        fr(CMD_HOLD, 32);
        chk(rx[15:0], INVALID_DATA);
        chk(16'(n_samp - s), 16'h0);
        // Standby keeps reference up, channels off, across hold frames
        fr(CMD_LIGHT, 16);
        chk({analog_on, ref_on, ch_power}, 16'h0300);
        fr(CMD_HOLD, 32);
        chk(rx[15:0], INVALID_DATA);
        chk({ref_on, ch_power}, 16'h0100);
    endtask

    task automatic t_abort();
        int s;
        fr(16'hc400, 16);
        fr(16'hc000, 8);
        s = n_samp;
        fr(CMD_HOLD, 32);
        chk(rx[15:0], INVALID_DATA);
        chk(16'(n_samp - s), 16'h0);
        // Unlisted mode code also leaves the block waiting
        fr(16'hc400, 16);
        fr(16'h8100, 16);
        s = n_samp;
        fr(CMD_HOLD, 32);
        chk(rx[15:0], INVALID_DATA);
        chk(16'(n_samp - s), 16'h0);
    endtask

    task automatic t_pin();
        int s;
        fr(CMD_AUTO, 16);
        wr(REG_RANGE0, 8'h77);
        @(posedge clk) hw_sleep_n <= 1'b0;
        repeat (8) @(posedge clk);
        chk(analog_on, 16'h0);
        hw_sleep_n <= 1'b1;
        repeat (8) @(posedge clk);
        rd(REG_RANGE0);
        chk(rx[7:0], 16'h0000);
        s = n_samp;
        fr(CMD_HOLD, 16);
        chk(16'(n_samp - s), 16'h0);
    endtask

    // Main sequence after a 16-cycle reset
    initial begin
        rst_n = 1'b0;
        hw_sleep_n = 1'b1;
        conv_data = CONV;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_defaults();
        t_manual();
        t_auto();
        t_sleep();
        t_regrst();
        t_abort();
        t_pin();
        final_report();
    end

    // Hang guard
    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        final_report();
    end
endmodule // adc_mode_command_sequencer_test
